// >>> timer16_waveform.sv
// timer16 waveform generator: ctc, fast pwm, phase correct pwm
// assumes: apb master on i_clk; pins resolved outside from oe
`include "timer16_consts.svh"

// Contract
// - modes 4 and 12 count up and clear after matching compare A or capture
// - in clear-on-match mode top match raises the top register's flag
// - clear-on-match top register writes act at once, unbuffered
// - top written below count: count on to 0xffff, wrap, then match
// - clear-on-match select 1 toggles output A on each match
// - waveform reaches the pin only when its direction bit is one
// - prescaler divides by 1, 8, 64, 256 or 1024
// - clear-on-match sets overflow when count passes max to zero
// - fast pwm counts single slope bottom to top then restarts
// - fast pwm top is fixed, capture or compare A; clears next tick
// - fast pwm select 2 clears on match, sets at bottom; 3 inverts
// - fast pwm sets overflow at top, plus top register's flag
// - each channel flags when count equals its compare value
// - fixed top masks compare bits above resolution on write
// - pwm compare A buffered, loaded at top; fast pwm clears and overflows there
// - capture used as top is unbuffered; low write wraps first
// - fast pwm compare zero gives spike, compare top a constant level
// - fast pwm select 1 toggles output A only in mode 15
// - fast pwm period is N times top plus one clocks
// - fast pwm top fixed 8/9/10 bit or variable from 0x0003
// - phase correct counts up and down; clears up, sets down
// - phase correct top fixed 8/9/10 bit or variable from 0x0003
// - phase correct modes 1-3 tops fixed; top held one tick
// - phase correct sets overflow at bottom
module timer16_waveform (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [1:0] o_wave_out,
  output logic [1:0] o_wave_out_oe
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  timer16_pkg::control_s ctl, next_ctl;
  timer16_pkg::flags_s flags, next_flags;
  logic [15:0] counter_value, next_counter_value;
  logic [15:0] compare_buf_a, next_compare_buf_a;
  logic [15:0] compare_a_value, next_compare_a_value;
  logic [15:0] compare_b_value, next_compare_b_value;
  logic [15:0] capture_value, next_capture_value;
  logic [1:0] pin_direction, next_pin_direction;
  logic [1:0] wave_out, next_wave_out;
  logic count_down, next_count_down;
  logic [31:0] prdata, next_prdata;
  logic tick;
  logic wr, rd, unmapped;
  logic [15:0] top, fix_mask;
  logic [1:0] kind;
  logic at_top, at_bottom;
  logic [1:0] match;
  logic [15:0] cmp [2];
  logic [1:0] sel [2];

  localparam logic [1:0] kind_normal = 2'h0;
  localparam logic [1:0] kind_ctc = 2'h1;
  localparam logic [1:0] kind_fast = 2'h2;
  localparam logic [1:0] kind_pc = 2'h3;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  function automatic logic [1:0] mode_kind(input logic [3:0] m);
    case (m)
      4'h4, 4'hc: mode_kind = kind_ctc;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: mode_kind = kind_fast;
      4'h1, 4'h2, 4'h3, 4'ha, 4'hb: mode_kind = kind_pc;
      default: mode_kind = kind_normal;
    endcase
  endfunction

  // fixed-top mask, all ones when top is not fixed
  function automatic logic [15:0] fixed_mask(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: fixed_mask = `TOP_8BIT;
      4'h2, 4'h6: fixed_mask = `TOP_9BIT;
      4'h3, 4'h7: fixed_mask = `TOP_10BIT;
      default: fixed_mask = `COUNT_MAX;
    endcase
  endfunction

  function automatic logic top_is_capture(input logic [3:0] m);
    top_is_capture = (m == 4'hc) || (m == 4'he) || (m == 4'ha);
  endfunction

  function automatic logic top_is_compare_a(input logic [3:0] m);
    top_is_compare_a = (m == 4'h4) || (m == 4'hf) || (m == 4'hb);
  endfunction

  timer16_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clock_select(ctl.clock_select),
    .o_tick(tick)
  );

  always_comb
  begin
    kind = mode_kind(ctl.waveform_mode_select);
    fix_mask = fixed_mask(ctl.waveform_mode_select);
    if (top_is_capture(ctl.waveform_mode_select))
      top = capture_value;
    else if (top_is_compare_a(ctl.waveform_mode_select))
      top = (kind == kind_ctc) ? compare_buf_a : compare_a_value;
    else if (kind == kind_normal)
      top = `COUNT_MAX;
    else
      top = fix_mask;
    at_top = (counter_value == top);
    at_bottom = (counter_value == `COUNT_BOTTOM);
    cmp[0] = (kind == kind_ctc) ? compare_buf_a : compare_a_value;
    cmp[1] = compare_b_value;
    sel[0] = ctl.compare_a_output_select;
    sel[1] = ctl.compare_b_output_select;
  end

  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_match
      assign match[c] = (counter_value == cmp[c]);
    end
  endgenerate

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  always_comb
  begin
    wr = i_psel && i_penable && i_pwrite;
    rd = i_psel && !i_penable && !i_pwrite;
    unmapped = i_paddr > `REG_DIRECTION || i_paddr[1:0] != 2'h0;
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && unmapped;
  assign o_prdata = prdata;

  always_comb
  begin
    next_prdata = prdata;
    if (rd)
    begin
      if (i_paddr == `REG_CONTROL)
        next_prdata = {21'h000000, ctl};
      else if (i_paddr == `REG_COMPARE_A)
        next_prdata = {16'h0000, compare_buf_a};
      else if (i_paddr == `REG_COMPARE_B)
        next_prdata = {16'h0000, compare_b_value};
      else if (i_paddr == `REG_CAPTURE)
        next_prdata = {16'h0000, capture_value};
      else if (i_paddr == `REG_COUNTER)
        next_prdata = {16'h0000, counter_value};
      else if (i_paddr == `REG_STATUS)
        next_prdata = {28'h0000000, flags.capture_flag,
          flags.compare_b_flag, flags.compare_a_flag, flags.overflow_flag};
      else if (i_paddr == `REG_DIRECTION)
        next_prdata = {30'h00000000, pin_direction};
      else
        next_prdata = 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // registers, counter and compare buffering
  // ------------------------------------------------------------
  always_comb
  begin
    next_ctl = ctl;
    next_compare_buf_a = compare_buf_a;
    next_compare_a_value = compare_a_value;
    next_compare_b_value = compare_b_value;
    next_capture_value = capture_value;
    next_pin_direction = pin_direction;
    next_counter_value = counter_value;
    next_count_down = count_down;
    if (wr)
    begin
      if (i_paddr == `REG_CONTROL)
        next_ctl = i_pwdata[10:0];
      else if (i_paddr == `REG_COMPARE_A)
        next_compare_buf_a = i_pwdata[15:0] & fix_mask;
      else if (i_paddr == `REG_COMPARE_B)
        next_compare_b_value = i_pwdata[15:0] & fix_mask;
      else if (i_paddr == `REG_CAPTURE)
        next_capture_value = i_pwdata[15:0];
      else if (i_paddr == `REG_COUNTER)
        next_counter_value = i_pwdata[15:0];
      else if (i_paddr == `REG_DIRECTION)
        next_pin_direction = i_pwdata[1:0];
    end
    // non-pwm modes have no buffering
    if (kind == kind_ctc || kind == kind_normal)
      next_compare_a_value = next_compare_buf_a;
    if (tick)
    begin
      case (kind)
        kind_ctc, kind_fast:
        begin
          next_count_down = 1'b0;
          if (at_top)
          begin
            next_counter_value = `COUNT_BOTTOM;
            if (kind == kind_fast)
              next_compare_a_value = compare_buf_a;
          end
          else
            next_counter_value = counter_value + 16'h0001;
        end
        kind_pc:
        begin
          if (at_top)
          begin
            next_count_down = 1'b1;
            next_compare_a_value = compare_buf_a;
            next_counter_value = counter_value - 16'h0001;
          end
          else if (count_down && at_bottom)
          begin
            next_count_down = 1'b0;
            next_counter_value = counter_value + 16'h0001;
          end
          else if (count_down)
            next_counter_value = counter_value - 16'h0001;
          else
            next_counter_value = counter_value + 16'h0001;
        end
        default:
          next_counter_value = counter_value + 16'h0001;
      endcase
    end
  end

  // ------------------------------------------------------------
  // flags: hardware set wins over write-one-to-clear
  // ------------------------------------------------------------
  always_comb
  begin
    next_flags = flags;
    if (wr && i_paddr == `REG_STATUS)
    begin
      next_flags.overflow_flag = flags.overflow_flag &
        ~i_pwdata[`ST_OVF_BIT];
      next_flags.compare_a_flag = flags.compare_a_flag &
        ~i_pwdata[`ST_CMPA_BIT];
      next_flags.compare_b_flag = flags.compare_b_flag &
        ~i_pwdata[`ST_CMPB_BIT];
      next_flags.capture_flag = flags.capture_flag &
        ~i_pwdata[`ST_CAP_BIT];
    end
    if (tick)
    begin
      if (match[0])
        next_flags.compare_a_flag = 1'b1;
      if (match[1])
        next_flags.compare_b_flag = 1'b1;
      if (at_top && top_is_capture(ctl.waveform_mode_select))
        next_flags.capture_flag = 1'b1;
      case (kind)
        kind_fast:
          if (at_top)
            next_flags.overflow_flag = 1'b1;
        kind_pc:
          if (count_down && at_bottom)
            next_flags.overflow_flag = 1'b1;
        default:
          if (counter_value == `COUNT_MAX)
            next_flags.overflow_flag = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // output compare units
  // ------------------------------------------------------------
  always_comb
  begin
    next_wave_out = wave_out;
    if (tick)
    begin
      for (int c = 0; c < 2; c++)
      begin
        case (kind)
          kind_fast:
          begin
            if (sel[c][1] && at_top)
              next_wave_out[c] = ~sel[c][0];
            else if (sel[c][1] && match[c])
              next_wave_out[c] = sel[c][0];
            else if (c == 0 && sel[c] == 2'h1 && match[c] &&
              ctl.waveform_mode_select == 4'hf)
              next_wave_out[c] = ~wave_out[c];
          end
          kind_pc:
          begin
            if (sel[c][1] && match[c])
              next_wave_out[c] = (count_down && !at_bottom) ^
                sel[c][0] ^ at_top;
            else if (c == 0 && sel[c] == 2'h1 && match[c] &&
              ctl.waveform_mode_select == 4'hb)
              next_wave_out[c] = ~wave_out[c];
          end
          default:
          begin
            if (match[c] && sel[c] == 2'h1)
              next_wave_out[c] = ~wave_out[c];
            else if (match[c] && sel[c][1])
              next_wave_out[c] = sel[c][0];
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctl <= '0;
      flags <= '0;
      counter_value <= 16'h0000;
      compare_buf_a <= 16'h0000;
      compare_a_value <= 16'h0000;
      compare_b_value <= 16'h0000;
      capture_value <= 16'h0000;
      pin_direction <= 2'h0;
      wave_out <= 2'h0;
      count_down <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ctl <= next_ctl;
      flags <= next_flags;
      counter_value <= next_counter_value;
      compare_buf_a <= next_compare_buf_a;
      compare_a_value <= next_compare_a_value;
      compare_b_value <= next_compare_b_value;
      capture_value <= next_capture_value;
      pin_direction <= next_pin_direction;
      wave_out <= next_wave_out;
      count_down <= next_count_down;
      prdata <= next_prdata;
    end
  end

  // select 0 leaves the pin to its port function
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_pin
      assign o_wave_out[c] = wave_out[c];
      assign o_wave_out_oe[c] = pin_direction[c] && (sel[c] != 2'h0);
    end
  endgenerate

endmodule

// >>> timer16_consts.svh
// timer16 waveform block: offsets, fields, top values, counts
// assumes: included by the main module, the prescaler, the checker and the testbench
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

`define REG_CONTROL     12'h000
`define REG_COMPARE_A   12'h004
`define REG_COMPARE_B   12'h008
`define REG_CAPTURE     12'h00c
`define REG_COUNTER     12'h010
`define REG_STATUS      12'h014
`define REG_DIRECTION   12'h018

// control register fields
`define CTL_MODE_LSB    0
`define CTL_CLKSEL_LSB  4
`define CTL_COMA_LSB    7
`define CTL_COMB_LSB    9

// status register fields, write one to clear
`define ST_OVF_BIT      0
`define ST_CMPA_BIT     1
`define ST_CMPB_BIT     2
`define ST_CAP_BIT      3

`define TOP_8BIT        16'h00ff
`define TOP_9BIT        16'h01ff
`define TOP_10BIT       16'h03ff
`define COUNT_MAX       16'hffff
`define COUNT_BOTTOM    16'h0000

`define DIV_8           10'h007
`define DIV_64          10'h03f
`define DIV_256         10'h0ff
`define DIV_1024        10'h3ff

`endif

// >>> timer16_pkg.sv
// timer16 waveform block: shared types
// assumes: constants come from timer16_consts.svh
package timer16_pkg;

  typedef enum logic [3:0] {
    wm_normal = 4'h0,
    wm_pc8 = 4'h1,
    wm_pc9 = 4'h2,
    wm_pc10 = 4'h3,
    wm_ctc_cmp = 4'h4,
    wm_fast8 = 4'h5,
    wm_fast9 = 4'h6,
    wm_fast10 = 4'h7,
    wm_pc_cap = 4'ha,
    wm_pc_cmp = 4'hb,
    wm_ctc_cap = 4'hc,
    wm_fast_cap = 4'he,
    wm_fast_cmp = 4'hf
  } waveform_mode_e;

  typedef enum logic [1:0] {
    cos_off = 2'h0,
    cos_toggle = 2'h1,
    cos_clear = 2'h2,
    cos_set = 2'h3
  } compare_output_select_e;

  typedef struct packed {
    logic overflow_flag;
    logic compare_a_flag;
    logic compare_b_flag;
    logic capture_flag;
  } flags_s;

  typedef struct packed {
    logic [1:0] compare_b_output_select;
    logic [1:0] compare_a_output_select;
    logic [2:0] clock_select;
    logic [3:0] waveform_mode_select;
  } control_s;

endpackage

// >>> timer16_prescaler.sv
// timer16 prescaler: one-cycle tick every N clocks
// assumes: same clock as the main block; select 0 stops the timer
`include "timer16_consts.svh"
module timer16_prescaler (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_clock_select,
  output logic o_tick
);

  logic [9:0] count;
  logic [9:0] next_count;
  logic [9:0] limit;

  always_comb
  begin
    case (i_clock_select)
      3'h2: limit = `DIV_8;
      3'h3: limit = `DIV_64;
      3'h4: limit = `DIV_256;
      3'h5: limit = `DIV_1024;
      default: limit = 10'h000;
    endcase
    if (i_clock_select == 3'h0 || count >= limit)
      next_count = 10'h000;
    else
      next_count = count + 10'h001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      count <= 10'h000;
    else
      count <= next_count;
  end

  assign o_tick = (i_clock_select != 3'h0) &&
    (i_clock_select <= 3'h5) && (count >= limit);

endmodule

// >>> timer16_waveform_monitor.sv
// checker for the apb answers, pin enables and outputs of the block
// assumes: bound onto timer16_waveform; master keeps the apb contract
`include "timer16_consts.svh"
module timer16_waveform_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [1:0] o_wave_out,
  input wire logic [1:0] o_wave_out_oe
);
  logic wr;
  logic [1:0] dir, next_dir;
  logic [6:0] ctl, next_ctl;
  assign wr = i_psel && i_penable && i_pwrite;
  // ---------------------------------------------
  // shadow of direction, selects and clock select
  // ---------------------------------------------
  always_comb
  begin
    next_dir = dir;
    next_ctl = ctl;
    if (wr && i_paddr == `REG_DIRECTION)
      next_dir = i_pwdata[1:0];
    if (wr && i_paddr == `REG_CONTROL)
      next_ctl = i_pwdata[10:4];
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dir <= 2'h0;
      ctl <= 7'h0;
    end
    else
    begin
      dir <= next_dir;
      ctl <= next_ctl;
    end
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  property p_ready;
    i_psel |-> o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_bad;
    i_psel && i_penable && (i_paddr > 12'h018 || i_paddr[1:0] != 2'h0)
      |-> o_pslverr;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("no slverr");
  property p_err_ok;
    i_psel && i_penable && i_paddr <= 12'h018 && i_paddr[1:0] == 2'h0
      |-> !o_pslverr;
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("false slverr");
  property p_err_idle;
    !(i_psel && i_penable) |-> !o_pslverr;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("idle slverr");
  property p_rd_hold;
    !$past(i_psel && !i_penable && !i_pwrite) |-> $stable(o_prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
  property p_rd_bad;
    i_psel && !i_penable && !i_pwrite && i_paddr > 12'h018
      |=> o_prdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped data");
  property p_oe;
    o_wave_out_oe == {dir[1] && ctl[6:5] != 2'h0, dir[0] && ctl[4:3] != 2'h0};
  endproperty
  a_oe: assert property (p_oe) else $error("bad pin enable");
  property p_stop;
    ctl[2:0] == 3'h0 && $past(ctl[2:0], 3) == 3'h0 |-> $stable(o_wave_out);
  endproperty
  a_stop: assert property (p_stop) else $error("output moved");
  property p_rst;
    $past(i_rst) |-> o_wave_out == 2'h0 && o_wave_out_oe == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule

bind timer16_waveform timer16_waveform_monitor timer16_waveform_monitor_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_wave_out(o_wave_out), .o_wave_out_oe(o_wave_out_oe));

// >>> tb_timer16_waveform.sv
// testbench: registers, ctc, fast and dual slope pwm of the timer block
// assumes: design and checker compiled first; 40 mhz clock
`include "timer16_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin $display("wrong value %s exp %h got %h", n, e, g); failures++; end end
module tb_timer16_waveform;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [1:0] o_wave_out, o_wave_out_oe;
  int failures = 0;
  int cmp_count = 0;
  timer16_waveform timer16_waveform_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_wave_out(o_wave_out), .o_wave_out_oe(o_wave_out_oe));
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------
  // apb master, control word, waveform timing
  // ---------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      wrap_up();
    end
    rd = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input int m, input int c, input int s);
    timer16_pkg::control_s v;
    v = '0;
    v.waveform_mode_select = 4'(m);
    v.clock_select = 3'(c);
    v.compare_a_output_select = 2'(s);
    return {21'h0, v};
  endfunction
  task automatic setup(input int m, c, s, ca, cp);
    apb(1'b1, `REG_CONTROL, ctl(m, 0, s));
    apb(1'b1, `REG_COUNTER, 0);
    apb(1'b1, `REG_COMPARE_A, ca);
    apb(1'b1, `REG_CAPTURE, cp);
    apb(1'b1, `REG_DIRECTION, 3);
    apb(1'b1, `REG_STATUS, 15);
    apb(1'b1, `REG_CONTROL, ctl(m, c, s));
  endtask
  task automatic wait_lvl(input int b, input logic v, output int n);
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end while (o_wave_out[b] !== v && n < 5000);
    if (n >= 5000)
    begin
      failures++;
      wrap_up();
    end
  endtask
  // length of one lv phase and of a whole period
  task automatic meas(input int b, input logic lv, output int hi, per);
    int n;
    wait_lvl(b, !lv, n);
    wait_lvl(b, lv, n);
    wait_lvl(b, !lv, hi);
    wait_lvl(b, lv, n);
    per = hi + n;
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs();
    for (int a = 0; a <= 24; a += 4)
    begin
      apb(1'b0, 12'(a), 0);
      `CHK("reset word", 32'h0, rd)
    end
    apb(1'b0, 12'h01c, 0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  task automatic t_div();
    int nv[5] = '{1, 8, 64, 256, 1024};
    int hi, per;
    for (int i = 0; i < 5; i++)
    begin
      setup(4, i + 1, 1, 1, 0);
      meas(0, 1'b1, hi, per);
      `CHK("half period", 2 * nv[i], hi)
    end
    `CHK("pin enable", 2'b01, o_wave_out_oe)
    apb(1'b1, `REG_DIRECTION, 0);
    @(negedge i_clk);
    `CHK("pin enable", 2'b00, o_wave_out_oe)
  endtask
  task automatic t_wrap();
    setup(4, 0, 0, 16, 0);
    apb(1'b1, `REG_COUNTER, 32'hfff0);
    apb(1'b1, `REG_CONTROL, ctl(4, 1, 0));
    apb(1'b0, `REG_STATUS, 0);
    `CHK("early flags", 32'h0, rd)
    repeat (40) @(posedge i_clk);
    apb(1'b0, `REG_STATUS, 0);
    `CHK("wrap flags", 32'h7, rd)
  endtask
  task automatic t_wave();
    int tv[10][7] = '{'{14, 2, 2, 7, 1, 3, 8}, '{14, 3, 2, 7, 0, 3, 8},
      '{14, 2, 0, 7, 1, 1, 8}, '{15, 1, 3, 0, 1, 4, 8},
      '{12, 1, 2, 5, 1, 6, 12}, '{10, 2, 2, 7, 1, 4, 14},
      '{5, 2, 16, 0, 1, 17, 256}, '{6, 2, 16, 0, 1, 17, 512},
      '{7, 2, 16, 0, 1, 17, 1024}, '{1, 2, 16, 0, 1, 32, 510}};
    int hi, per;
    for (int i = 0; i < 10; i++)
    begin
      setup(tv[i][0], 1, tv[i][1], tv[i][2], tv[i][3]);
      meas(0, 1'(tv[i][4]), hi, per);
      `CHK("active time", tv[i][5], hi)
      `CHK("period", tv[i][6], per)
      if (i == 0)
      begin
        apb(1'b0, `REG_STATUS, 0);
        `CHK("top flags", 32'hf, rd)
      end
    end
  endtask
  task automatic t_chan_b();
    int hi, per;
    setup(14, 1, 0, 7, 7);
    apb(1'b1, `REG_COMPARE_B, 4);
    apb(1'b1, `REG_CONTROL, ctl(14, 1, 0) | (32'h2 << `CTL_COMB_LSB));
    meas(1, 1'b1, hi, per);
    `CHK("b active time", 5, hi)
    `CHK("b period", 8, per)
    `CHK("b pin enable", 2'b10, o_wave_out_oe)
    apb(1'b0, `REG_STATUS, 0);
    `CHK("b flags", 32'hf, rd)
  endtask
  task automatic t_edge();
    setup(14, 1, 2, 7, 7);
    repeat (16) @(negedge i_clk);
    repeat (16)
    begin
      @(negedge i_clk);
      `CHK("steady level", 1'b1, o_wave_out[0])
    end
    apb(1'b1, `REG_CONTROL, ctl(5, 0, 0));
    for (int a = 4; a <= 8; a += 4)
    begin
      apb(1'b1, 12'(a), 32'hffff);
      apb(1'b0, 12'(a), 0);
      `CHK("masked compare", 32'h00ff, rd)
    end
  endtask
  initial
  begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_div();
    t_wrap();
    t_wave();
    t_chan_b();
    t_edge();
    wrap_up();
  end
endmodule
